/* lps_afe_model.sv */
`timescale 1ns/100ps
// ====
// Front end stand-in: one charge packet per cycle while lit
module lps_afe_model (
	// Clock
	input  wire logic ref_clk,
	// Scene
	input  wire logic bright,
	// Pulses
	output logic      adc_charge_pulse
);
	always_ff @(posedge ref_clk)
		adc_charge_pulse <= bright;
endmodule // lps_afe_model

/* lps_pkg.sv */
package lps_pkg;

	// ==========================================================
	// Measurement kinds
	typedef enum logic [1:0]
	{
		LPS_MEAS_AMB,
		LPS_MEAS_IR,
		LPS_MEAS_PROX
	} lps_meas_t;

	// ==========================================================
	// Command register II settings
	typedef struct packed
	{
		logic [1:0] led_current_select;
		logic [1:0] led_mod_select;
		logic [1:0] resolution_field;
		logic [1:0] range_select;
	} lps_cfg_t;

	// ==========================================================
	// Result bytes, always written as one unit
	typedef struct packed
	{
		logic [7:0] msb;
		logic [7:0] lsb;
	} lps_data_t;

endpackage

/* lps_regs.svh */
`ifndef LPS_REGS_SVH
`define LPS_REGS_SVH

// ==========================================================
// Operation field codes
`define LPS_OP_DOWN        3'h0
`define LPS_OP_RESERVED    3'h4
`define LPS_OP_CONT_BIT    2

// ==========================================================
// Resolution field codes and cycles per conversion
`define LPS_RES_16         2'h0
`define LPS_RES_12         2'h1
`define LPS_RES_8          2'h2
`define LPS_RES_4          2'h3
`define LPS_CYC_16         17'h10000
`define LPS_CYC_12         17'h01000
`define LPS_CYC_8          17'h00100
`define LPS_CYC_4          17'h00010
`define LPS_MAX_16         16'hffff
`define LPS_MAX_12         16'h0fff
`define LPS_MAX_8          16'h00ff
`define LPS_MAX_4          16'h000f

// ==========================================================
// LED modulation codes and timing
`define LPS_MOD_DC         2'h0
`define LPS_MOD_360K       2'h3
`define LPS_CLK_FREQ_KHZ   10000
`define LPS_MOD_FREQ_KHZ   360
`define LPS_MOD_HALF_CYC   ((`LPS_CLK_FREQ_KHZ + `LPS_MOD_FREQ_KHZ) / (2 * `LPS_MOD_FREQ_KHZ))

// ==========================================================
// Reset values
`define LPS_DATA_RST       16'h0000

`endif

/* lps_sequencer.sv */
`timescale 1ns/100ps
`include "lps_regs.svh"

module lps_sequencer #(
	parameter logic [16:0] INT_CYC_16 = `LPS_CYC_16
) (
	// Clock and reset
	input  wire logic              ref_clk,
	input  wire logic              arst_n,
	// Host commands
	input  wire logic              op_write,
	input  wire logic [2:0]        operation_field,
	input  wire lps_pkg::lps_cfg_t cfg_in,
	input  wire logic              ext_timing_mode,
	input  wire logic              ext_timing_cmd,
	// Charge-balance comparator pulses from the analog front end
	input  wire logic              adc_charge_pulse,
	// Results and status
	output lps_pkg::lps_data_t     data_q,
	output logic                   powered_down_q,
	output logic                   integrating_q,
	output logic                   ambient_light_measure_q,
	output logic                   ir_measure_q,
	// Analog and LED control
	output logic [1:0]             adc_range_q,
	output logic [1:0]             led_current_select_q,
	output logic                   ir_led_drive_output_q
);

	// ==========================================================
	// Helpers
	function automatic logic [16:0] res_cycles(input logic [1:0] res);
		case (res)
			`LPS_RES_16: res_cycles = INT_CYC_16;
			`LPS_RES_12: res_cycles = `LPS_CYC_12;
			`LPS_RES_8:  res_cycles = `LPS_CYC_8;
			default:     res_cycles = `LPS_CYC_4;
		endcase
	endfunction

	function automatic logic [15:0] res_clip(input logic [1:0] res, input logic [16:0] v);
		logic [15:0] lim;
		lim = `LPS_MAX_4;
		case (res)
			`LPS_RES_16: lim = `LPS_MAX_16;
			`LPS_RES_12: lim = `LPS_MAX_12;
			`LPS_RES_8:  lim = `LPS_MAX_8;
			default:     lim = `LPS_MAX_4;
		endcase
		res_clip = (v > {1'b0, lim}) ? lim : v[15:0];
	endfunction

	// ==========================================================
	// State
	typedef enum logic [1:0]
	{
		ST_DOWN,
		ST_ARMED,
		ST_INTEG
	} lps_state_t;

	localparam logic [4:0] MOD_HALF = 5'(`LPS_MOD_HALF_CYC);

	lps_state_t         state_q, state_d;
	lps_pkg::lps_meas_t meas_q, meas_d;
	logic               cont_q, cont_d;
	lps_pkg::lps_cfg_t  cfg_q, cfg_d;
	logic [16:0]        cyc_q, cyc_d;
	logic [16:0]        cnt_q, cnt_d;
	logic [4:0]         mod_cnt_q, mod_cnt_d;
	logic               phase_q, phase_d;
	lps_pkg::lps_data_t data_d;
	logic               led_d;
	logic               start;
	logic               finish;

	// ==========================================================
	// Sequencer next state
	always_comb
	begin
		state_d = state_q;
		meas_d  = meas_q;
		cont_d  = cont_q;
		cfg_d   = cfg_q;
		cyc_d   = cyc_q;
		cnt_d   = cnt_q;
		data_d  = data_q;
		start   = 1'b0;
		finish  = 1'b0;

		if (state_q == ST_INTEG)
		begin
			cyc_d = cyc_q + 17'h00001;
			if (adc_charge_pulse && cnt_q != 17'h1ffff)
				cnt_d = cnt_q + 17'h00001;
			if (ext_timing_mode)
				finish = ext_timing_cmd;
			else
				finish = (cyc_q + 17'h00001 >= res_cycles(cfg_q.resolution_field));
		end
		else if (state_q == ST_ARMED && ext_timing_cmd)
			start = 1'b1;

		// Conversion end: both bytes in one write
		if (finish)
		begin
			if (ext_timing_mode)
				data_d = lps_pkg::lps_data_t'(res_clip(`LPS_RES_16, cyc_q));
			else
				data_d = lps_pkg::lps_data_t'(res_clip(cfg_q.resolution_field, cnt_d));
			if (cont_q)
			begin
				start = 1'b1;
				if (ext_timing_mode)
					start = 1'b1;
			end
			else
				state_d = ST_DOWN;
		end

		// A fresh command other than the reserved code overrides whatever runs
		if (op_write && operation_field != `LPS_OP_RESERVED)
		begin
			if (operation_field == `LPS_OP_DOWN)
			begin
				state_d = ST_DOWN;
				start   = 1'b0;
			end
			else
			begin
				cont_d = operation_field[`LPS_OP_CONT_BIT];
				case (operation_field[1:0])
					2'h1:    meas_d = lps_pkg::LPS_MEAS_AMB;
					2'h2:    meas_d = lps_pkg::LPS_MEAS_IR;
					default: meas_d = lps_pkg::LPS_MEAS_PROX;
				endcase
				if (ext_timing_mode)
				begin
					state_d = ST_ARMED;
					start   = 1'b0;
				end
				else
					start = 1'b1;
			end
		end

		if (start)
		begin
			state_d = ST_INTEG;
			cfg_d   = cfg_in;
			cyc_d   = 17'h00000;
			cnt_d   = 17'h00000;
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state_q <= ST_DOWN;
			meas_q  <= lps_pkg::LPS_MEAS_AMB;
			cont_q  <= 1'b0;
			cfg_q   <= '0;
			cyc_q   <= 17'h00000;
			cnt_q   <= 17'h00000;
			data_q  <= `LPS_DATA_RST;
		end
		else
		begin
			state_q <= state_d;
			meas_q  <= meas_d;
			cont_q  <= cont_d;
			cfg_q   <= cfg_d;
			cyc_q   <= cyc_d;
			cnt_q   <= cnt_d;
			data_q  <= data_d;
		end
	end

	// ==========================================================
	// LED modulation and drive
	always_comb
	begin
		mod_cnt_d = mod_cnt_q;
		phase_d   = phase_q;
		// Entry restarts the period so the first high half is full length
		if (state_d != ST_INTEG || state_q != ST_INTEG)
		begin
			mod_cnt_d = 5'h00;
			phase_d   = 1'b1;
		end
		else if (mod_cnt_q + 5'h01 >= MOD_HALF)
		begin
			mod_cnt_d = 5'h00;
			phase_d   = ~phase_q;
		end
		else
			mod_cnt_d = mod_cnt_q + 5'h01;

		// Unlisted modulation codes fall back to DC drive
		led_d = (state_d == ST_INTEG) && (meas_d == lps_pkg::LPS_MEAS_PROX);
		if (cfg_d.led_mod_select == `LPS_MOD_360K)
			led_d = led_d && phase_d;
	end

	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			mod_cnt_q               <= 5'h00;
			phase_q                 <= 1'b1;
			ir_led_drive_output_q   <= 1'b0;
			led_current_select_q    <= 2'h0;
			adc_range_q             <= 2'h0;
			powered_down_q          <= 1'b1;
			integrating_q           <= 1'b0;
			ambient_light_measure_q <= 1'b0;
			ir_measure_q            <= 1'b0;
		end
		else
		begin
			mod_cnt_q               <= mod_cnt_d;
			phase_q                 <= phase_d;
			ir_led_drive_output_q   <= led_d;
			led_current_select_q    <= cfg_d.led_current_select;
			adc_range_q             <= cfg_d.range_select;
			powered_down_q          <= (state_d == ST_DOWN);
			integrating_q           <= (state_d == ST_INTEG);
			ambient_light_measure_q <= (state_d != ST_DOWN) && (meas_d == lps_pkg::LPS_MEAS_AMB);
			ir_measure_q            <= (state_d != ST_DOWN) && (meas_d != lps_pkg::LPS_MEAS_AMB);
		end
	end

endmodule // lps_sequencer

/* lps_sequencer_chk.sv */
`timescale 1ns/100ps
module lps_sequencer_chk (
	// Clock and reset
	input wire logic              ref_clk,
	input wire logic              arst_n,
	// Commands
	input wire logic              op_write,
	input wire logic [2:0]        operation_field,
	input wire lps_pkg::lps_cfg_t cfg_in,
	input wire logic              ext_timing_mode,
	// Status
	input wire lps_pkg::lps_data_t data_q,
	input wire logic              powered_down_q,
	input wire logic              integrating_q,
	input wire logic              ambient_light_measure_q,
	input wire logic              ir_measure_q,
	input wire logic              ir_led_drive_output_q
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	wire go = op_write && !ext_timing_mode;
	wire [1:0] k = operation_field[1:0];
	property p_down; op_write && operation_field == 3'h0 |=> powered_down_q && !integrating_q;
	endproperty
	a_down: assert property (p_down) else $error("no power-down");
	property p_start; go && k != 2'h0 |=> integrating_q && !powered_down_q; endproperty
	a_start: assert property (p_start) else $error("command not taken");
	property p_rsvd; powered_down_q && op_write && operation_field == 3'h4 |=> powered_down_q;
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved code acted on");
	property p_amb; op_write && k == 2'h1 |=> ambient_light_measure_q && !ir_measure_q;
	endproperty
	a_amb: assert property (p_amb) else $error("ambient kind wrong");
	property p_prox; op_write && k == 2'h3 |=> ir_measure_q && !ambient_light_measure_q;
	endproperty
	a_prox: assert property (p_prox) else $error("proximity kind wrong");
	property p_led; ir_led_drive_output_q |-> integrating_q && ir_measure_q; endproperty
	a_led: assert property (p_led) else $error("led on outside sensing");
	property p_upd; !$stable(data_q) |-> $past(integrating_q); endproperty
	a_upd: assert property (p_upd) else $error("data moved without conversion");
	property p_once;
		go && operation_field == 3'h1 && cfg_in.resolution_field == 2'h3
		|=> integrating_q[*8] ##[7:9] (powered_down_q && !integrating_q);
	endproperty
	a_once: assert property (p_once) else $error("one-shot did not end");
	property p_cont; go && operation_field[2] && k != 2'h0 |=> integrating_q[*8]; endproperty
	a_cont: assert property (p_cont) else $error("continuous stopped");
	c_once: cover property (go && operation_field == 3'h1);
	c_cont: cover property (go && operation_field == 3'h7);
	c_ext: cover property (ext_timing_mode && !$stable(data_q));
endmodule // lps_sequencer_chk

bind lps_sequencer lps_sequencer_chk i_lps_sequencer_chk (.ref_clk, .arst_n, .op_write,
	.operation_field, .cfg_in, .ext_timing_mode, .data_q, .powered_down_q, .integrating_q,
	.ambient_light_measure_q, .ir_measure_q, .ir_led_drive_output_q);

/* lps_sequencer_tb.sv */
`timescale 1ns/100ps
`include "lps_regs.svh"
module lps_sequencer_tb;
	logic              ref_clk = 1'b0;
	logic              arst_n = 1'b0;
	logic              op_write = 1'b0;
	logic [2:0]        operation_field = 3'h0;
	lps_pkg::lps_cfg_t cfg_in = 8'h00;
	logic              ext_timing_mode = 1'b0;
	logic              ext_timing_cmd = 1'b0;
	logic              bright = 1'b1;
	logic              adc_charge_pulse;
	lps_pkg::lps_data_t data_q;
	logic              powered_down_q, integrating_q, ambient_light_measure_q, ir_measure_q;
	logic              ir_led_drive_output_q;
	logic [1:0]        adc_range_q, led_current_select_q;
	logic [1:0]        rs [4] = '{2'h3, 2'h2, 2'h0, 2'h1};
	int                cy [4] = '{16, 256, 64, 4096};
	logic [15:0]       dv [4] = '{16'h000f, 16'h00ff, 16'h0000, 16'h0fff};
	int                n_mismatch = 0;
	int                total_checks = 0;
	int                n, l;
	always #50 ref_clk = ~ref_clk;
	lps_afe_model i_lps_afe_model (.ref_clk, .bright, .adc_charge_pulse);
	// Short full-resolution count keeps the run brief
	lps_sequencer #(.INT_CYC_16(17'h00040)) i_lps_sequencer (.ref_clk, .arst_n, .op_write,
		.operation_field, .cfg_in, .ext_timing_mode, .ext_timing_cmd, .adc_charge_pulse,
		.data_q, .powered_down_q, .integrating_q, .ambient_light_measure_q, .ir_measure_q,
		.adc_range_q, .led_current_select_q, .ir_led_drive_output_q);
	// ====
	// Tasks
	task automatic chk(input logic [16:0] seen, input logic [16:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic close_out;
		$display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic cmd(input logic [2:0] op, input logic [7:0] cfg);
		@(negedge ref_clk);
		op_write = 1'b1;
		operation_field = op;
		cfg_in = cfg;
		@(negedge ref_clk);
		op_write = 1'b0;
	endtask
	// Counts integration cycles and lit cycles; a hang ends the run
	task automatic run(output int c, output int lit);
		c = 0;
		lit = 0;
		while (integrating_q === 1'b1)
		begin
			c++;
			lit += (ir_led_drive_output_q === 1'b1);
			if (c > 5000)
			begin
				n_mismatch++;
				close_out();
			end
			@(negedge ref_clk);
		end
	endtask
	task automatic runlen(input logic v, output int c);
		c = 0;
		while (ir_led_drive_output_q === v && c < 100)
		begin
			c++;
			@(negedge ref_clk);
		end
	endtask
	// ====
	// Sequence
	initial
	begin
		repeat (12) @(negedge ref_clk);
		arst_n = 1'b1;
		repeat (5) @(negedge ref_clk);
		chk(data_q, 16'h0000);
		chk(powered_down_q, 1'b1);
		chk(integrating_q, 1'b0);
		$display("test reset done");
		for (int i = 0; i < 4; i++)
		begin
			bright = (i != 2);
			// Second pass takes the infrared one-shot code
			cmd((i == 1) ? 3'h2 : 3'h1, {4'h0, rs[i], 2'h0});
			run(n, l);
			chk(n, cy[i]);
			chk(l, 0);
			repeat (20) @(negedge ref_clk);
			chk(data_q, dv[i]);
			chk(powered_down_q, 1'b1);
		end
		$display("test one-shot done");
		bright = 1'b1;
		cmd(3'h4, 8'h0c);
		chk(powered_down_q, 1'b1);
		chk(integrating_q, 1'b0);
		cmd(3'h3, 8'h4d);
		run(n, l);
		chk(l, 16);
		chk(led_current_select_q, 2'h1);
		chk(adc_range_q, 2'h1);
		$display("test dc proximity done");
		cmd(3'h7, 8'hbb);
		runlen(1'b1, n);
		chk(n, `LPS_MOD_HALF_CYC);
		runlen(1'b0, n);
		chk(n, `LPS_MOD_HALF_CYC);
		repeat (300) @(negedge ref_clk);
		chk(integrating_q, 1'b1);
		chk(data_q, 16'h00ff);
		chk(led_current_select_q, 2'h2);
		chk(adc_range_q, 2'h3);
		$display("test continuous proximity done");
		cmd(3'h5, 8'h0c);
		chk(ambient_light_measure_q, 1'b1);
		cmd(3'h6, 8'h0c);
		chk(ir_measure_q, 1'b1);
		chk(ambient_light_measure_q, 1'b0);
		repeat (20) @(negedge ref_clk);
		cmd(3'h0, 8'h0c);
		chk(powered_down_q, 1'b1);
		chk(integrating_q, 1'b0);
		$display("test mode switch done");
		ext_timing_mode = 1'b1;
		cmd(3'h5, 8'h0c);
		repeat (3) @(negedge ref_clk);
		ext_timing_cmd = 1'b1;
		@(negedge ref_clk);
		ext_timing_cmd = 1'b0;
		repeat (9) @(negedge ref_clk);
		ext_timing_cmd = 1'b1;
		@(negedge ref_clk);
		ext_timing_cmd = 1'b0;
		chk(data_q, 16'h0009);
		cmd(3'h0, 8'h0c);
		$display("test external timing done");
		close_out();
	end
endmodule // lps_sequencer_tb
